// *** rtl/pwmc_submodule.sv ***
// Submodule timebase: counter, buffered start count, two control registers.
// Assumes AHB-Lite single word transfers; pins from other domains.
`timescale 1ns/1ps
module pwmc_submodule #(
  parameter bit IS_SM0 = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sync_pin,
  input  wire logic        force_pin,
  input  wire logic        timer_sourced_clock,
  input  wire logic        aux_pin,
  input  wire logic        dt0_end,
  input  wire logic        dt1_end,
  input  wire logic        debug_mode,
  input  wire logic        sleep_mode,
  input  wire logic        m_reload,
  input  wire logic        m_sync,
  input  wire logic        m_force,
  input  wire logic        m_commit,
  input  wire logic        m_aux_clk,
  output logic             reload_out,
  output logic             sync_out,
  output logic             force_out,
  output logic             aux_clk_out,
  output logic             outputs_en,
  output logic             pair_mode_sel,
  output logic             a_out,
  output logic             b_out,
  output logic             x_out,
  output logic signed [15:0] count_value
);
  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int B_DBG   = pwmc_pkg::B_DBG;
  localparam int B_SLP   = pwmc_pkg::B_SLP;
  localparam int B_PAIR  = pwmc_pkg::B_PAIR;
  localparam int B_ALVL  = pwmc_pkg::B_ALVL;
  localparam int B_BLVL  = pwmc_pkg::B_BLVL;
  localparam int B_XLVL  = pwmc_pkg::B_XLVL;
  localparam int B_ISEL  = pwmc_pkg::B_ISEL;
  localparam int B_OVR   = pwmc_pkg::B_OVR;
  localparam int B_FRC   = pwmc_pkg::B_FRC;
  localparam int B_FSEL  = pwmc_pkg::B_FSEL;
  localparam int B_RSEL  = pwmc_pkg::B_RSEL;
  localparam int B_CSEL  = pwmc_pkg::B_CSEL;
  localparam int A_RATE  = pwmc_pkg::A_RATE;
  localparam int A_HALF  = pwmc_pkg::A_HALF;
  localparam int A_FULL  = pwmc_pkg::A_FULL;
  localparam int A_DT    = pwmc_pkg::A_DT;
  localparam int A_CLOCK_DIVIDER  = pwmc_pkg::A_CLOCK_DIVIDER;
  localparam int A_IMMEDIATE_REFRESH_SEL = pwmc_pkg::A_IMMEDIATE_REFRESH_SEL;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic        dph;
    logic        dwr;
    logic [7:0]  dad;
    logic [15:0] cnt;
    logic [15:0] init_buf;
    logic [15:0] init_act;
    logic [15:0] ctlb;
    logic [15:0] ctla;
    logic [2:0]  clock_divider_act;
    logic [3:0]  rate_act;
    logic [3:0]  opp_cnt;
    logic [6:0]  div;
    logic [15:0] mid_point_value;
    logic [15:0] modulo_value;
    logic        commit;
    logic        commit_prev;
    logic        lsync;
    logic        lreload;
    logic        xo;
    logic        ao;
    logic        bo;
    logic        frc_pulse;
    logic        fout;
    logic        clk_prev;
    logic        init_pend;
    logic        upd_pend;
    logic        oe;
    logic [31:0] rdata;
  } pwmc_state_t;
  pwmc_state_t st_q;
  pwmc_state_t st_d;

  logic [5:0] pins_s;
  logic       sync_s;
  logic       force_s;
  logic       tclk_s;
  logic       aux_s;
  logic       dt0_s;
  logic       dt1_s;

  pwmc_sync2 #(.W(6)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({sync_pin, force_pin, timer_sourced_clock, aux_pin, dt0_end, dt1_end}),
    .dout (pins_s)
  );
  assign {sync_s, force_s, tclk_s, aux_s, dt0_s, dt1_s} = pins_s;

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  logic [1:0]  isel;
  logic [2:0]  fsel;
  logic [1:0]  csel;
  logic        src_clk;
  logic        tick;
  logic        init_sig;
  logic        force_sig;
  logic        reload_sig;
  logic        eff_commit;
  logic        opp;
  logic        mod_hit;
  logic        mid_hit;
  logic        wr;
  logic        rd;
  logic [15:0] wd;
  logic        do_load;
  logic        do_init;
  logic [6:0]  div_mask;

  always_comb
  begin
    st_d = st_q;
    isel = st_q.ctlb[B_ISEL+:2];
    fsel = st_q.ctlb[B_FSEL+:3];
    csel = st_q.ctlb[B_CSEL+:2];
    wd   = hwdata[15:0];
    // Clock source selection
    case (csel) // R16
      pwmc_pkg::CSEL_BUS: src_clk = ~st_q.clk_prev;
      pwmc_pkg::CSEL_TMR: src_clk = tclk_s;
      pwmc_pkg::CSEL_AUX: src_clk = IS_SM0 ? 1'b0 : m_aux_clk;
      default:            src_clk = 1'b0;
    endcase
    st_d.clk_prev = src_clk;
    div_mask = 7'((8'h01 << st_q.clock_divider_act) - 8'h01); // R21
    if (csel == pwmc_pkg::CSEL_BUS)
      tick = (st_q.div & div_mask) == div_mask;
    else
      tick = src_clk & ~st_q.clk_prev & ((st_q.div & div_mask) == div_mask);
    if (csel == pwmc_pkg::CSEL_BUS || (src_clk & ~st_q.clk_prev))
      st_d.div = st_q.div + 7'h01;
    mod_hit = tick && (st_q.cnt == st_q.modulo_value);
    mid_hit = tick && (st_q.cnt == st_q.mid_point_value);
    // Init source selection
    case (isel) // R9
      pwmc_pkg::ISEL_LSYNC: init_sig = mod_hit; // Sync event, not the level
      pwmc_pkg::ISEL_MRLD:  init_sig = IS_SM0 ? 1'b0 : m_reload; // R10
      pwmc_pkg::ISEL_MSYNC: init_sig = IS_SM0 ? 1'b0 : m_sync; // R10
      default:              init_sig = sync_s;
    endcase
    case (fsel) // R13
      pwmc_pkg::FSEL_LOCAL: force_sig = st_q.frc_pulse; // R12
      pwmc_pkg::FSEL_MFRC:  force_sig = IS_SM0 ? 1'b0 : m_force; // R14
      pwmc_pkg::FSEL_LRLD:  force_sig = st_q.lreload;
      pwmc_pkg::FSEL_MRLD:  force_sig = IS_SM0 ? 1'b0 : m_reload; // R14
      pwmc_pkg::FSEL_LSYNC: force_sig = st_q.lsync;
      pwmc_pkg::FSEL_MSYNC: force_sig = IS_SM0 ? 1'b0 : m_sync; // R14
      pwmc_pkg::FSEL_PIN:   force_sig = force_s;
      default:              force_sig = 1'b0;
    endcase
    // Reload opportunity and rate
    opp = (st_q.ctla[A_HALF] & mid_hit) | (st_q.ctla[A_FULL] & mod_hit); // R18 R19
    reload_sig = 1'b0;
    if (opp)
    begin
      if (st_q.opp_cnt >= st_q.rate_act) // R17
      begin
        st_d.opp_cnt  = 4'h0;
        st_d.rate_act = st_q.ctla[A_RATE+:4];
        reload_sig    = 1'b1;
      end
      else
        st_d.opp_cnt = st_q.opp_cnt + 4'h1;
    end
    st_d.lreload = reload_sig;
    if (st_q.ctlb[B_RSEL]) // R15
    begin
      eff_commit = IS_SM0 ? 1'b0 : m_commit;
      reload_sig = IS_SM0 ? 1'b0 : m_reload;
    end
    else
      eff_commit = st_q.commit;
    st_d.commit_prev = eff_commit;
    // Buffer transfer
    if (st_q.ctla[A_IMMEDIATE_REFRESH_SEL]) // R22
      do_load = eff_commit & ~st_q.commit_prev;
    else
      do_load = reload_sig & eff_commit;
    if (do_load) // R4
    begin
      st_d.init_act = st_q.init_buf;
      st_d.upd_pend = 1'b1;
      if (st_q.commit && !st_q.ctlb[B_RSEL])
        st_d.commit = 1'b0;
    end
    if (st_q.upd_pend && mod_hit) // R21
    begin
      st_d.clock_divider_act = st_q.ctla[A_CLOCK_DIVIDER+:3];
      st_d.upd_pend = 1'b0;
    end
    // Counter
    do_init = init_sig | (force_sig & st_q.ctlb[B_OVR]); // R2 R11
    if (do_init)
      st_d.cnt = st_q.init_act;
    else if (mod_hit)
      st_d.cnt = st_q.init_act; // R3 R23
    else if (tick)
      st_d.cnt = st_q.cnt + 16'h0001; // R25
    // Local sync and aux output
    if (mod_hit)
    begin
      st_d.lsync = 1'b1; // R23
      st_d.xo    = 1'b0;
    end
    else if (mid_hit)
    begin
      st_d.lsync = 1'b0; // R24
      st_d.xo    = 1'b1;
    end
    st_d.fout = force_sig; // R14
    if (force_sig) // R8 R12
    begin
      st_d.ao = st_q.ctlb[B_ALVL];
      st_d.bo = st_q.ctlb[B_BLVL];
      st_d.xo = st_q.ctlb[B_XLVL];
    end
    if (st_q.ctlb[B_PAIR] == 1'b0) // R7
      st_d.bo = ~st_d.ao;
    st_d.oe = (~debug_mode | st_q.ctlb[B_DBG]) & (~sleep_mode | st_q.ctlb[B_SLP]); // R5 R6
    // Deadtime samples
    if (dt0_s)
      st_d.ctla[A_DT] = aux_s; // R20
    if (dt1_s)
      st_d.ctla[A_DT+1] = aux_s; // R20
    // Bus
    st_d.frc_pulse = 1'b0;
    wr = st_q.dph & st_q.dwr;
    rd = hsel & hready & htrans[1] & ~hwrite;
    st_d.dph = hsel & hready & htrans[1];
    st_d.dwr = hwrite;
    st_d.dad = haddr;
    if (wr)
    begin
      case (st_q.dad)
        pwmc_pkg::ADDR_INIT: if (!st_q.commit) st_d.init_buf = wd; // R4
        pwmc_pkg::ADDR_CTLB:
        begin
          st_d.ctlb = wd & pwmc_pkg::CTLB_WMASK; // R26
          st_d.frc_pulse = wd[B_FRC];
        end
        pwmc_pkg::ADDR_CTLA:
        begin
          st_d.ctla[A_RATE+:4] = wd[A_RATE+:4];
          st_d.ctla[A_HALF] = wd[A_HALF];
          st_d.ctla[A_FULL] = wd[A_FULL];
          st_d.ctla[A_IMMEDIATE_REFRESH_SEL] = wd[A_IMMEDIATE_REFRESH_SEL];
          if (!st_q.commit)
            st_d.ctla[A_CLOCK_DIVIDER+:3] = wd[A_CLOCK_DIVIDER+:3]; // R21
          if (st_q.ctla[A_IMMEDIATE_REFRESH_SEL] && !st_q.commit)
            st_d.upd_pend = 1'b1;
        end
        pwmc_pkg::ADDR_MID: st_d.mid_point_value = wd;
        pwmc_pkg::ADDR_MOD: st_d.modulo_value = wd;
        pwmc_pkg::ADDR_CMT:
        begin
          if (wd[0]) st_d.commit = 1'b1;
          else if (wd[1]) st_d.commit = 1'b0;
        end
        default: ;
      endcase
    end
    st_d.rdata = 32'h0;
    if (rd)
    begin
      case (haddr)
        pwmc_pkg::ADDR_CNT:  st_d.rdata = {16'h0, st_d.cnt}; // R1
        pwmc_pkg::ADDR_INIT: st_d.rdata = {16'h0, st_q.init_buf};
        pwmc_pkg::ADDR_CTLB: st_d.rdata = {16'h0, st_q.ctlb};
        pwmc_pkg::ADDR_CTLA: st_d.rdata = {16'h0, st_q.ctla};
        pwmc_pkg::ADDR_MID:  st_d.rdata = {16'h0, st_q.mid_point_value};
        pwmc_pkg::ADDR_MOD:  st_d.rdata = {16'h0, st_q.modulo_value};
        pwmc_pkg::ADDR_CMT:  st_d.rdata = {31'h0, st_q.commit};
        pwmc_pkg::ADDR_STAT: st_d.rdata = {29'h0, st_q.upd_pend, st_q.lsync, st_q.xo};
        default:             st_d.rdata = 32'h0;
      endcase
    end
    st_d.init_pend = do_init;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q <= '0;
      st_q.modulo_value <= pwmc_pkg::MOD_RST;
    end
    else
      st_q <= st_d;
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign hrdata        = st_q.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign reload_out    = st_q.lreload;
  assign sync_out      = st_q.lsync;
  assign force_out     = st_q.fout;
  assign aux_clk_out   = st_q.clk_prev;
  assign outputs_en    = st_q.oe;
  assign pair_mode_sel = st_q.ctlb[B_PAIR];
  assign a_out         = st_q.ao & st_q.oe;
  assign b_out         = st_q.bo & st_q.oe;
  assign x_out         = st_q.xo & st_q.oe;
  assign count_value   = st_q.cnt;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  chk_init_load: assert property (@(posedge clk) disable iff (rst) // R2
    st_q.init_pend |-> st_q.cnt == $past(st_q.init_act))
    else $error("counter not loaded from start count");
  chk_commit_block: assert property (@(posedge clk) disable iff (rst) // R4
    (wr && st_q.dad == pwmc_pkg::ADDR_INIT && st_q.commit)
    |=> st_q.init_buf == $past(st_q.init_buf))
    else $error("start count written while committed");
  chk_debug_off: assert property (@(posedge clk) disable iff (rst) // R5
    (debug_mode && !st_q.ctlb[B_DBG] && !sleep_mode) |=> !outputs_en)
    else $error("outputs live in debug mode");
  chk_sleep_off: assert property (@(posedge clk) disable iff (rst) // R6
    (sleep_mode && !st_q.ctlb[B_SLP]) |=> !outputs_en)
    else $error("outputs live in wait mode");
  chk_pair_comp: assert property (@(posedge clk) disable iff (rst) // R7
    !st_q.ctlb[B_PAIR] |=> st_q.bo == ~st_q.ao)
    else $error("pair not complementary");
  chk_sync_mod: assert property (@(posedge clk) disable iff (rst) // R23
    (mod_hit && !force_sig) |=> st_q.lsync && !st_q.xo)
    else $error("modulo match effects missing");
  chk_mid_point: assert property (@(posedge clk) disable iff (rst) // R24
    (mid_hit && !mod_hit && !force_sig) |=> !st_q.lsync && st_q.xo)
    else $error("mid point effects missing");
  chk_count_step: assert property (@(posedge clk) disable iff (rst) // R25
    (tick && !mod_hit && !do_init) |=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
    else $error("counter did not step");
endmodule

// *** rtl/pwmc_pkg.sv ***
// Constants for one motor-control PWM submodule timebase and control.
// Assumes an AHB-Lite register bus and a single 100 MHz clock.
// Operation
// [R1] Counter reads back as a signed 16-bit whole value, read only.
// [R2] Selected init signal, or external force with override enabled, loads start count.
// [R3] Active start count enters the counter at each PWM cycle start.
// [R4] Start count double buffered; writes blocked while commit flag set.
// [R5] Debug mode disables outputs unless debug-run bit set.
// [R6] Wait mode disables outputs unless sleep-run bit set.
// [R7] Pair mode bit: 0 complementary A/B, 1 independent A/B.
// [R8] Three start-level bits forced onto A, B, X on force-initialize.
// [R9] Init source field: local sync, master reload, master sync, sync pin.
// [R10] Submodule 0 holds init low for master reload or master sync settings.
// [R11] With override enabled, force initializes counter regardless of init source.
// [R12] Writing local force bit makes a force-out event when source is local.
// [R13] Force source field: seven sources in order, 111 reserved.
// [R14] Submodule 0 holds force low for master-signal force settings.
// [R15] Reload source bit: local or submodule 0 master reload with its commit flag.
// [R16] Clock source field: bus clock, timer clock, submodule 0 aux clock.
// [R17] Refresh rate reloads every N+1 opportunities, applied after current load cycle.
// [R18] Half-cycle bit makes every mid-point match a reload opportunity.
// [R19] Full-cycle bit makes every modulo match a reload opportunity.
// [R20] Aux pin sampled at end of each deadtime into two status bits.
// [R21] Prescaler divides by power of two, buffered, writes blocked while committed.
// [R22] Load mode: at next reload if committed, or immediately on commit.
// [R23] Modulo match reloads counter, asserts local sync, resets aux output.
// [R24] Mid-point match sets aux output and resets local sync.
// [R25] Counter advances by one per prescaled tick, signed 16-bit.
// [R26] Software writes zero to reserved bits; they read as zero.
package pwmc_pkg;
  localparam logic [7:0] ADDR_CNT   = 8'h00;
  localparam logic [7:0] ADDR_INIT  = 8'h04;
  localparam logic [7:0] ADDR_CTLB  = 8'h08;
  localparam logic [7:0] ADDR_CTLA  = 8'h0c;
  localparam logic [7:0] ADDR_MID   = 8'h10;
  localparam logic [7:0] ADDR_MOD   = 8'h14;
  localparam logic [7:0] ADDR_CMT   = 8'h18;
  localparam logic [7:0] ADDR_STAT  = 8'h1c;
  // Control b bit positions
  localparam int B_DBG   = 15;
  localparam int B_SLP   = 14;
  localparam int B_PAIR  = 13;
  localparam int B_ALVL  = 12;
  localparam int B_BLVL  = 11;
  localparam int B_XLVL  = 10;
  localparam int B_ISEL  = 8;
  localparam int B_OVR   = 7;
  localparam int B_FRC   = 6;
  localparam int B_FSEL  = 3;
  localparam int B_RSEL  = 2;
  localparam int B_CSEL  = 0;
  // Control a bit positions
  localparam int A_RATE  = 12;
  localparam int A_HALF  = 11;
  localparam int A_FULL  = 10;
  localparam int A_DT    = 8;
  localparam int A_CLOCK_DIVIDER  = 4;
  localparam int A_IMMEDIATE_REFRESH_SEL = 2;
  localparam logic [15:0] CTLB_WMASK = 16'hffbf;
  localparam logic [15:0] CTLA_WMASK = 16'hfc04;
  localparam logic [15:0] RST_VAL    = 16'h0000;
  localparam logic [15:0] MID_RST    = 16'h0000;
  localparam logic [15:0] MOD_RST    = 16'h00ff;
  localparam logic [1:0] ISEL_LSYNC = 2'h0;
  localparam logic [1:0] ISEL_MRLD  = 2'h1;
  localparam logic [1:0] ISEL_MSYNC = 2'h2;
  localparam logic [1:0] ISEL_PIN   = 2'h3;
  localparam logic [2:0] FSEL_LOCAL = 3'h0;
  localparam logic [2:0] FSEL_MFRC  = 3'h1;
  localparam logic [2:0] FSEL_LRLD  = 3'h2;
  localparam logic [2:0] FSEL_MRLD  = 3'h3;
  localparam logic [2:0] FSEL_LSYNC = 3'h4;
  localparam logic [2:0] FSEL_MSYNC = 3'h5;
  localparam logic [2:0] FSEL_PIN   = 3'h6;
  localparam logic [1:0] CSEL_BUS   = 2'h0;
  localparam logic [1:0] CSEL_TMR   = 2'h1;
  localparam logic [1:0] CSEL_AUX   = 2'h2;
endpackage

// *** rtl/pwmc_sync2.sv ***
// Two-flop synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module pwmc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pwmc_sync_t;
  pwmc_sync_t st_q;
  pwmc_sync_t st_d;

  always_comb
  begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign dout = st_q.s2;
endmodule

// *** tb/pwmc_far_side.sv ***
// Far-side model: submodule 0 signals, sync and force pins, two slow clocks.
// Assumes cmd changes just after a rising clk edge.
`timescale 1ns/1ps
module pwmc_far_side (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] cmd,
  output logic            m_reload,
  output logic            m_sync,
  output logic            sync_pin,
  output logic            m_force,
  output logic            force_pin,
  output logic            dt0_end,
  output logic            dt1_end,
  output logic            aux_pin,
  output logic            timer_sourced_clock,
  output logic            m_aux_clk
);
  logic [4:0] div_q;
  // ----------------------------------------
  // Lines follow cmd one cycle late; clocks of period 6 and 8
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    {aux_pin, dt1_end, dt0_end, force_pin, m_force, sync_pin, m_sync, m_reload} <= cmd;
    div_q <= (rst || div_q == 5'd23) ? 5'd0 : div_q + 5'd1;
    timer_sourced_clock <= (div_q % 5'd6) < 5'd3;
    m_aux_clk <= (div_q % 5'd8) < 5'd4;
  end
endmodule

// *** tb/pwm_submodule_counter_control_bench.sv ***
// Self-checking bench for one PWM submodule timebase and control.
// Assumes the far-side model and a zero-wait AHB-Lite slave.
`timescale 1ns/1ps
module pwm_submodule_counter_control_bench;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               hsel = 1'b0;
  logic        [7:0]  haddr = 8'h00;
  logic        [1:0]  htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic        [2:0]  hsize = 3'h2;
  logic        [31:0] hwdata = 32'h0;
  logic               debug_mode = 1'b0;
  logic               sleep_mode = 1'b0;
  logic               m_commit = 1'b0;
  logic        [7:0]  cmd = 8'h00;
  logic               mon_on = 1'b0;
  logic               saw_f = 1'b0;
  logic signed [15:0] prev_c = 16'sh0;
  logic signed [15:0] act_init = 16'sh0;
  logic signed [15:0] c0;
  logic        [15:0] v;
  logic        [31:0] r;
  int                 num_errors = 0;
  int                 checks = 0;
  int                 n;
  wire logic        [31:0] hrdata;
  wire logic signed [15:0] count_value;
  wire logic hreadyout, m_reload, m_sync, sync_pin, m_force, force_pin, dt0_end, dt1_end;
  wire logic aux_pin, timer_sourced_clock, m_aux_clk, force_out, outputs_en, pair_mode_sel;
  wire logic a_out, b_out;
  localparam logic [15:0] MODES [5] = '{16'h0400, 16'h0404, 16'h0800, 16'h1400, 16'h0000};
  localparam logic [15:0] TCTL [7] = '{16'h0100, 16'h0200, 16'h0300, 16'h1088, 16'h10b0,
                                       16'h10c0, 16'h0030};
  localparam logic [7:0]  TCMD [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00, 8'h10};
  localparam logic [7:0]  DCMD [5] = '{8'ha0, 8'h80, 8'h00, 8'h40, 8'h00};

  pwmc_submodule #(.IS_SM0(1'b0)) dut (
    .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp(), .sync_pin, .force_pin, .timer_sourced_clock, .aux_pin, .dt0_end,
    .dt1_end, .debug_mode, .sleep_mode, .m_reload, .m_sync, .m_force, .m_commit, .m_aux_clk,
    .reload_out(), .sync_out(), .force_out, .aux_clk_out(), .outputs_en, .pair_mode_sel,
    .a_out, .b_out, .x_out(), .count_value);
  pwmc_far_side far (.clk, .rst, .cmd, .m_reload, .m_sync, .sync_pin, .m_force, .force_pin,
    .dt0_end, .dt1_end, .aux_pin, .timer_sourced_clock, .m_aux_clk);

  always #5 clk = ~clk;

  // ----------------------------------------
  // Bus cycles, comparison and verdict
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; read data lands in r
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    cmp(r, {16'h0, e});
  endtask

  task automatic wait_count(input logic signed [15:0] k);
    n = 0;
    while (count_value !== k && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000)
      num_errors++;
  endtask

  // Counter model: steps by one, wraps to the active start count
  always @(posedge clk)
  begin
    if (mon_on)
      cmp({16'h0, count_value}, {16'h0, (prev_c == pwmc_pkg::MOD_RST) ?
          act_init : prev_c + 16'sh1});
    prev_c <= count_value;
    if (force_out === 1'b1)
      saw_f <= 1'b1;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    test_done;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(35675));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    mon_on <= 1'b1;
    bus(1'b1, 8'h00, 16'h1234);
    rd(8'h04, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h0c, 16'h0000);
    rd(8'h14, pwmc_pkg::MOD_RST);
    rd(8'h20, 16'h0000);
    $display("test reset values done");
    mon_on <= 1'b0;
    repeat (4)
    begin
      v = 16'($urandom);
      bus(1'b1, 8'h08, v);
      rd(8'h08, v & pwmc_pkg::CTLB_WMASK);
      cmp(32'(pair_mode_sel), 32'(v[13]));
      v = 16'($urandom) & 16'hfc74;
      bus(1'b1, 8'h0c, v);
      rd(8'h0c, v);
    end
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h0c, 16'h0000);
    $display("test control registers done");
    foreach (MODES[i])
    begin
      mon_on <= 1'b0;
      v = 16'hffc0 | 16'($urandom_range(63));
      bus(1'b1, 8'h04, v);
      rd(8'h04, v);
      bus(1'b1, 8'h0c, MODES[i]);
      bus(1'b1, 8'h18, 16'h0001);
      if (i == 0)
      begin
        bus(1'b1, 8'h04, ~v);
        bus(1'b1, 8'h0c, MODES[i] | 16'h0070);
        rd(8'h04, v);
        rd(8'h0c, MODES[i]);
      end
      n = 0;
      do
      begin
        bus(1'b0, 8'h18, 16'h0);
        n++;
      end
      while (r[0] !== 1'b0 && n < 400);
      cmp(32'(r[0]), 32'(MODES[i] == 16'h0));
      if (MODES[i] != 16'h0)
        act_init <= v;
      bus(1'b1, 8'h18, 16'h0002);
      mon_on <= 1'b1;
      repeat (400) @(posedge clk);
      $display("test buffered start count mode %0d done", i);
    end
    foreach (TCTL[i])
    begin
      mon_on <= 1'b0;
      saw_f <= 1'b0;
      wait_count(16'sd100);
      bus(1'b1, 8'h08, TCTL[i]);
      cmd <= TCMD[i];
      repeat (3) @(posedge clk);
      cmd <= 8'h00;
      repeat (6) @(posedge clk);
      cmp(32'(count_value < act_init + 16'sd16), 32'(i != 6));
      if (TCTL[i][7])
      begin
        cmp(32'(saw_f), 32'h1);
        cmp(32'({a_out, b_out}), 32'h2);
      end
      bus(1'b1, 8'h08, 16'h0000);
      $display("test counter trigger %0d done", i);
    end
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h08, 16'(i) << 14);
      debug_mode <= 1'b1;
      repeat (4) @(posedge clk);
      cmp(32'(outputs_en), 32'(i >> 1));
      debug_mode <= 1'b0;
      sleep_mode <= 1'b1;
      repeat (4) @(posedge clk);
      cmp(32'(outputs_en), 32'(i & 1));
      sleep_mode <= 1'b0;
      repeat (4) @(posedge clk);
      cmp(32'(outputs_en), 32'h1);
    end
    bus(1'b1, 8'h08, 16'h0000);
    $display("test debug and wait modes done");
    foreach (DCMD[i])
    begin
      cmd <= DCMD[i];
      repeat (4) @(posedge clk);
    end
    rd(8'h0c, 16'h0100);
    $display("test deadtime samples done");
    for (int s = 1; s < 3; s++)
    begin
      wait_count(16'sd10);
      bus(1'b1, 8'h08, 16'(s));
      c0 = count_value;
      repeat (96) @(posedge clk);
      n = int'(count_value - c0);
      cmp(32'(n >= 16 - 4 * s && n <= 24 - 4 * s), 32'h1);
      bus(1'b1, 8'h08, 16'h0000);
    end
    $display("test clock sources done");
    test_done;
  end
endmodule
